// ### xyds_asserts.sv
// xyds_asserts.sv: port-level timing checker for the word sequencer, bound to it.
// assumes the control register is written through the low byte lane.
`timescale 1ns/10ps
module xyds_checker #(
    parameter WORD_CYC = 20,
    parameter PT_WAIT_CYC = 10,
    parameter PT_ON_CYC = 5
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [4:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire plot_done_pulse_i,
    input wire [10:0] x_dac_o,
    input wire [10:0] y_dac_o,
    input wire beam_on_o,
    input wire marker_o,
    input wire word_ready_flag_o
);
    // ==================================================
    // mode shadow and beam length counter
    reg [3:0] ctl_ff;
    reg [9:0] bcnt_ff;
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr_word = req && wb_we_i && wb_adr_i[4:2] == 3'h0;
    wire pt_mode = ctl_ff[1:0] == 2'h1 || (ctl_ff[1] && ctl_ff[2]);
    wire bar_mode = ctl_ff[1] && !ctl_ff[2] && !ctl_ff[3];
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctl_ff <= 4'h0;
            bcnt_ff <= 10'h000;
        end else begin
            bcnt_ff <= beam_on_o ? bcnt_ff + 10'h001 : 10'h000;
            if (req && wb_we_i && wb_adr_i[4:2] == 3'h2 && wb_sel_i[0]) begin
                ctl_ff <= wb_dat_i[3:0];
            end
        end
    end
    default clocking dcb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // ==================================================
    // properties
    reset_vals_a: assert property (disable iff (1'b0) rst_i |=> word_ready_flag_o &&
        !beam_on_o && y_dac_o == 11'h400) else $error("reset values wrong");
    ack_once_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one pulse");
    ready_drop_a: assert property (wr_word && word_ready_flag_o |=> !word_ready_flag_o)
        else $error("ready kept after word");
    ready_hold_a: assert property ($fell(word_ready_flag_o) |-> !word_ready_flag_o[*8])
        else $error("ready back too early");
    x_keep_a: assert property (wr_word && !word_ready_flag_o |=> $stable(x_dac_o))
        else $error("word taken while busy");
    pt_width_a: assert property (pt_mode && $fell(beam_on_o) |-> bcnt_ff == PT_ON_CYC)
        else $error("point beam width wrong");
    continuous_xy_type_beam_a: assert property (!pt_mode && !ctl_ff[3] && $rose(beam_on_o)
        |-> beam_on_o[*8]) else $error("beam too short");
    bar_mid_a: assert property (bar_mode && $fell(beam_on_o) |-> ##[0:1] y_dac_o == 11'h400)
        else $error("bar not back to midscale");
    beam_rdy_a: assert property (!ctl_ff[3] && $rose(word_ready_flag_o) |-> !beam_on_o)
        else $error("beam on at ready");
    point_cov: cover property (pt_mode && $fell(beam_on_o));
    busy_cov: cover property (wr_word && !word_ready_flag_o);
    plot_cov: cover property (plot_done_pulse_i && !word_ready_flag_o);
endmodule // xyds_checker

bind xyds_word_sequencer xyds_checker #(.WORD_CYC(WORD_CYC), .PT_WAIT_CYC(PT_WAIT_CYC),
    .PT_ON_CYC(PT_ON_CYC)) chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .plot_done_pulse_i(plot_done_pulse_i), .x_dac_o(x_dac_o), .y_dac_o(y_dac_o),
    .beam_on_o(beam_on_o), .marker_o(marker_o), .word_ready_flag_o(word_ready_flag_o));

// ### xyds_plotter_model.sv
// xyds_plotter_model.sv: external plotter, pulses done a fixed time after the latest word taken.
// assumes the ready flag marks when a word is taken.
`timescale 1ns/10ps
module xyds_plotter_model #(
    parameter DELAY = 60
) (
    input wire clk_i,
    input wire rst_i,
    input wire en_i,
    input wire word_ready_flag_i,
    output reg plot_done_pulse_o
);
    reg [7:0] cnt_ff;
    reg run_ff;
    reg rdy_ff;
    // each new word restarts the pen move, so a stale move never ends early
    always @(posedge clk_i) begin
        rdy_ff <= word_ready_flag_i;
        plot_done_pulse_o <= 1'b0;
        if (rst_i || !en_i) begin
            run_ff <= 1'b0;
        end else if (rdy_ff && !word_ready_flag_i) begin
            run_ff <= 1'b1;
            cnt_ff <= 8'h00;
        end else if (run_ff) begin
            cnt_ff <= cnt_ff + 8'h01;
            if (cnt_ff == DELAY - 1) begin
                run_ff <= 1'b0;
                plot_done_pulse_o <= 1'b1;
            end
        end
    end
endmodule // xyds_plotter_model

// ### xyds_regs.vh
// xyds_regs.vh: register map, field positions, reset values and timing constants
// for the xy display word sequencer. definitions only; included by the top module.
`ifndef XYDS_REGS_VH
`define XYDS_REGS_VH

// ==========================================================================
// register byte offsets (one aligned 32-bit word each)
// ==========================================================================
`define XYDS_OFS_WORD 5'h00
`define XYDS_OFS_STATUS 5'h04
`define XYDS_OFS_CTRL 5'h08
`define XYDS_OFS_PANEL 5'h0c
`define XYDS_OFS_COORD 5'h10

// ==========================================================================
// status fields
// ==========================================================================
`define XYDS_ST_READY 0
`define XYDS_ST_BEAM 1
`define XYDS_ST_CNT_LO 2
`define XYDS_ST_CNT_HI 3
`define XYDS_ST_STALL 4

// ==========================================================================
// control fields and reset value
// ==========================================================================
`define XYDS_CT_TYPE_LO 0
`define XYDS_CT_TYPE_HI 1
`define XYDS_CT_COMPLEX 2
`define XYDS_CT_PLOT 3
`define XYDS_CT_ARM 4
`define XYDS_CT_MK8 5
`define XYDS_CT_MK32 6
`define XYDS_CT_SW_LO 8
`define XYDS_CT_SW_HI 15
`define XYDS_CTRL_RST 16'h0000

// display type encodings
`define XYDS_TYPE_CONTINUOUS_XY_TYPE 2'h0
`define XYDS_TYPE_POINT 2'h1
`define XYDS_TYPE_BAR 2'h2

// word counter values
`define XYDS_CNT_ZERO 2'h0
`define XYDS_CNT_ONE 2'h1
`define XYDS_CNT_X 2'h2
`define XYDS_CNT_Y 2'h3

// ==========================================================================
// timing, in nanoseconds at a 10 MHz clock (period 100 ns)
// ==========================================================================
`define XYDS_CLK_NS 100
`define XYDS_WORD_NS 35000
`define XYDS_PT_WAIT_NS 25000
`define XYDS_PT_ON_NS 10000
`define XYDS_WORD_CYC (`XYDS_WORD_NS / `XYDS_CLK_NS)
`define XYDS_PT_WAIT_CYC ((`XYDS_PT_WAIT_NS + `XYDS_CLK_NS - 1) / `XYDS_CLK_NS)
`define XYDS_PT_ON_CYC (`XYDS_PT_ON_NS / `XYDS_CLK_NS)

// midscale code of an 11-bit converter
`define XYDS_MID_SCALE 11'h400

`endif

// ### xyds_word_sequencer.v
// xyds_word_sequencer.v: word sequencing and beam timing of the xy display unit.
// assumes one 10 MHz clock, a synchronous active-high reset, a classic wishbone
// master for the registers, and panel/plotter inputs already synchronous.
`timescale 1ns/10ps

`include "xyds_regs.vh"

module xyds_word_sequencer #(
    parameter WORD_CYC = `XYDS_WORD_CYC,
    parameter PT_WAIT_CYC = `XYDS_PT_WAIT_CYC,
    parameter PT_ON_CYC = `XYDS_PT_ON_CYC
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [4:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire plot_done_pulse_i,
    output reg [10:0] x_dac_o,
    output reg [10:0] y_dac_o,
    output reg beam_on_o,
    output reg marker_o,
    output reg word_ready_flag_o
);

    // ======================================================================
    // states (one-hot)
    // ======================================================================
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_WAIT = 4'b0010;
    localparam [3:0] ST_ARM = 4'b0100;
    localparam [3:0] ST_PLOT = 4'b1000;

    reg [3:0] state_ff;
    reg [1:0] cnt_ff;
    reg [15:0] ctrl_ff;
    reg [15:0] panel1_ff;
    reg [15:0] panel2_ff;
    reg [10:0] x_hold_ff;
    reg [7:0] sw_cap_ff;
    reg [15:0] timer_ff;
    reg [4:0] mark_ff;
    reg [3:0] nxt_state;

    // ======================================================================
    // decode helpers
    // ======================================================================
    function hit;
        input [4:0] adr;
        input [4:0] ofs;
        begin
            hit = (adr[4:2] == ofs[4:2]);
        end
    endfunction

    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr = req & wb_we_i;
    wire [1:0] dtype = ctrl_ff[`XYDS_CT_TYPE_HI:`XYDS_CT_TYPE_LO];
    wire complex_mode = ctrl_ff[`XYDS_CT_COMPLEX];
    wire plot_sel = ctrl_ff[`XYDS_CT_PLOT];
    wire arm_sel = ctrl_ff[`XYDS_CT_ARM];
    wire continuous_xy_type = (dtype == `XYDS_TYPE_CONTINUOUS_XY_TYPE);
    // complex mode forces point behaviour over bar
    wire point_type = (dtype == `XYDS_TYPE_POINT) | (complex_mode & ~continuous_xy_type);
    wire bar_type = ~continuous_xy_type & ~point_type;
    wire word_count_is_zero = (cnt_ff == `XYDS_CNT_ZERO);
    wire word_count_is_x = (cnt_ff == `XYDS_CNT_X);
    wire word_count_is_y = (cnt_ff == `XYDS_CNT_Y);
    wire marker_every_eighth = ctrl_ff[`XYDS_CT_MK8];
    wire marker_every_thirty_second = ctrl_ff[`XYDS_CT_MK32];

    // a word write counts as an encode strobe only while ready is up
    wire strobe = wr & hit(wb_adr_i, `XYDS_OFS_WORD) & (&wb_sel_i[1:0])
        & word_ready_flag_o & state_ff[0];
    wire [15:0] word = wb_dat_i[15:0];
    wire first_word = ~word[0];
    wire [1:0] nxt_cnt = first_word ? `XYDS_CNT_ZERO :
        (word_count_is_y ? `XYDS_CNT_X : cnt_ff + 2'h1);

    wire timer_done = (timer_ff == 16'h0000);

    // ======================================================================
    // sequencer state machine
    // ======================================================================
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (strobe) begin
                    nxt_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (timer_done) begin
                    if (word_count_is_zero & plot_sel) begin
                        nxt_state = ST_ARM;
                    end else if (word_count_is_y & plot_sel & arm_sel) begin
                        nxt_state = ST_PLOT;
                    end else begin
                        nxt_state = ST_IDLE;
                    end
                end
            end
            ST_ARM: begin
                if (arm_sel) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_PLOT: begin
                if (plot_done_pulse_i) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    wire release_ready = (nxt_state == ST_IDLE) & ~state_ff[0];

    always @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= ST_IDLE;
            cnt_ff <= `XYDS_CNT_ZERO;
            word_ready_flag_o <= 1'b1;
            timer_ff <= 16'h0000;
            sw_cap_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            if (strobe) begin
                word_ready_flag_o <= 1'b0;
                cnt_ff <= nxt_cnt;
                timer_ff <= WORD_CYC[15:0] - 16'h0001;
            end else if (!timer_done) begin
                timer_ff <= timer_ff - 16'h0001;
            end
            if (release_ready) begin
                word_ready_flag_o <= 1'b1;
                sw_cap_ff <= ctrl_ff[`XYDS_CT_SW_HI:`XYDS_CT_SW_LO];
            end
        end
    end

    // ======================================================================
    // word storage and converters
    // ======================================================================
    always @(posedge clk_i) begin
        if (rst_i) begin
            panel1_ff <= 16'h0000;
            panel2_ff <= 16'h0000;
            x_hold_ff <= 11'h000;
            x_dac_o <= 11'h000;
            y_dac_o <= `XYDS_MID_SCALE;
        end else if (strobe) begin
            if (first_word) begin
                panel1_ff <= {word[15:1], 1'b0};
            end else if (word_count_is_zero) begin
                panel2_ff <= {word[15:1], 1'b0};
            end else if (word_count_is_x) begin
                // vertical goes straight out; held x joins it in continuous type
                y_dac_o <= word[15:5];
                if (continuous_xy_type) begin
                    x_dac_o <= x_hold_ff;
                end
            end else begin
                x_hold_ff <= word[15:5];
                if (!continuous_xy_type) begin
                    x_dac_o <= word[15:5];
                end
            end
        end else if (state_ff[1] && timer_done && word_count_is_y && bar_type) begin
            y_dac_o <= `XYDS_MID_SCALE;
        end
    end

    // ======================================================================
    // beam unblanking and markers
    // ======================================================================
    // elapsed time since the vertical load, used for the point window
    wire [15:0] elapsed = WORD_CYC[15:0] - 16'h0001 - timer_ff;
    // window is judged one cycle ahead because beam_on_o is registered; this keeps
    // the full on-time inside the interval even when wait plus on fills all of it
    wire [15:0] elapsed_nxt = elapsed + 16'h0001;
    wire pt_window = (elapsed_nxt >= PT_WAIT_CYC[15:0])
        & (elapsed_nxt < PT_WAIT_CYC[15:0] + PT_ON_CYC[15:0]);
    wire y_active = state_ff[1] & word_count_is_y & ~timer_done;
    // mark_ff already counts the point on show, so the eighth point sees a count of 8
    wire mark_hit = marker_every_thirty_second ? (mark_ff == 5'h00) :
        (marker_every_eighth & (mark_ff[2:0] == 3'h0));

    always @(posedge clk_i) begin
        if (rst_i) begin
            beam_on_o <= 1'b0;
            marker_o <= 1'b0;
            mark_ff <= 5'h00;
        end else begin
            if (y_active) begin
                beam_on_o <= point_type ? pt_window : 1'b1;
            end else begin
                beam_on_o <= 1'b0;
            end
            marker_o <= y_active & mark_hit;
            if (strobe & first_word) begin
                mark_ff <= 5'h00;
            end else if (strobe & word_count_is_x) begin
                mark_ff <= mark_ff + 5'h01;
            end
        end
    end

    // ======================================================================
    // wishbone slave: single wait-free ack one cycle after request
    // ======================================================================
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff <= `XYDS_CTRL_RST;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req;
            if (wr & hit(wb_adr_i, `XYDS_OFS_CTRL)) begin
                if (wb_sel_i[0]) begin
                    ctrl_ff[7:0] <= wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    ctrl_ff[15:8] <= wb_dat_i[15:8];
                end
            end
            wb_dat_o <= 32'h00000000;
            if (req & ~wb_we_i) begin
                if (hit(wb_adr_i, `XYDS_OFS_STATUS)) begin
                    wb_dat_o <= {24'h000000, sw_cap_ff} << 8 |
                        {27'h0000000, ~state_ff[0] & ~state_ff[1], cnt_ff,
                         beam_on_o, word_ready_flag_o};
                end else if (hit(wb_adr_i, `XYDS_OFS_CTRL)) begin
                    wb_dat_o <= {16'h0000, ctrl_ff};
                end else if (hit(wb_adr_i, `XYDS_OFS_PANEL)) begin
                    wb_dat_o <= {panel2_ff, panel1_ff};
                end else if (hit(wb_adr_i, `XYDS_OFS_COORD)) begin
                    wb_dat_o <= {5'h00, y_dac_o, 5'h00, x_dac_o};
                end
            end
        end
    end

endmodule // xyds_word_sequencer

// ### xyds_word_sequencer_test.sv
// xyds_word_sequencer_test.sv: self-checking bench for the word sequencer.
// assumes short timing parameters and the plotter model on the done input.
`timescale 1ns/10ps
module xyds_word_sequencer_test;
    localparam int WC = 20;
    localparam int PO = 5;
    reg clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, plot_en = 0;
    reg [4:0] wb_adr_i = 0;
    reg [3:0] wb_sel_i = 4'hf;
    reg [31:0] wb_dat_i = 0, rd;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, plot_done, beam_on_o, marker_o, word_ready_flag_o;
    wire [10:0] x_dac_o, y_dac_o;
    int n_errors = 0, compares = 0, lat, bon, mk;
    xyds_word_sequencer #(.WORD_CYC(WC), .PT_WAIT_CYC(10), .PT_ON_CYC(PO)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .plot_done_pulse_i(plot_done),
        .x_dac_o(x_dac_o), .y_dac_o(y_dac_o), .beam_on_o(beam_on_o), .marker_o(marker_o),
        .word_ready_flag_o(word_ready_flag_o));
    xyds_plotter_model #(.DELAY(60)) plotter (.clk_i(clk_i), .rst_i(rst_i), .en_i(plot_en),
        .word_ready_flag_i(word_ready_flag_o), .plot_done_pulse_o(plot_done));
    // ==================================================
    // shared tasks
    task automatic summarize;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic cmp(input string what, input [31:0] exp, input [31:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wb(input we, input [4:0] a, input [31:0] d);
        int k;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 100);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        cmp("ack", 1, wb_ack_o);
    endtask
    task automatic wait_ready;
        lat = 0;
        bon = 0;
        mk = 0;
        while (word_ready_flag_o !== 1'b1 && lat < 1000) begin
            @(posedge clk_i);
            lat++;
            bon += (beam_on_o === 1'b1);
            mk += (marker_o === 1'b1);
        end
        cmp("ready", 1, word_ready_flag_o);
    endtask
    task automatic word(input [15:0] w);
        wb(1, 5'h00, {16'h0, w});
        wait_ready();
    endtask
    task automatic count_is(input [1:0] c);
        wb(0, 5'h04, 0);
        cmp("counter", c, rd[3:2]);
    endtask
    // ==================================================
    // scenarios
    task automatic t_reset;
        wb(0, 5'h04, 0);
        cmp("status", 32'h1, rd[4:0]);
        cmp("y reset", 11'h400, y_dac_o);
        wb(0, 5'h1c, 32'hffff_ffff);
        cmp("unmapped", 0, rd);
    endtask
    task automatic t_continuous_xy_type;
        wb(1, 5'h08, 32'h0000_a500);
        word(16'h1234);
        cmp("latency", 1, lat >= WC - 2 && lat <= WC + 2);
        wb(0, 5'h04, 0);
        cmp("switches", 8'ha5, rd[15:8]);
        cmp("counter", 0, rd[3:2]);
        wb(1, 5'h08, 32'h0000_5a00);
        word(16'habcd);
        wb(0, 5'h04, 0);
        cmp("switches", 8'h5a, rd[15:8]);
        cmp("counter", 1, rd[3:2]);
        wb(0, 5'h0c, 0);
        cmp("panel", 32'habcc_1234, rd);
        word(16'h2aa1);
        cmp("x held", 0, x_dac_o);
        count_is(2);
        word(16'h5541);
        cmp("y", 11'h2aa, y_dac_o);
        cmp("x", 11'h155, x_dac_o);
        cmp("continuous_xy_type beam", 1, bon >= WC - 3);
        count_is(3);
    endtask
    task automatic t_point;
        wb(1, 5'h08, 32'h1);
        word(16'h1e01);
        cmp("x now", 11'h0f0, x_dac_o);
        count_is(2);
        wb(1, 5'h00, 32'h7fe1);
        wb(1, 5'h00, 32'h7fe1);
        wait_ready();
        cmp("busy x", 11'h0f0, x_dac_o);
        count_is(3);
        wb(1, 5'h08, 32'h6);
        word(16'h0801);
        word(16'h7fe1);
        cmp("complex beam", PO, bon);
    endtask
    task automatic t_bar;
        wb(1, 5'h08, 32'h2);
        word(16'h0801);
        word(16'h7fe1);
        cmp("bar beam", 1, bon >= WC - 3);
        cmp("mid", 11'h400, y_dac_o);
        cmp("beam off", 0, beam_on_o);
    endtask
    task automatic t_plot;
        wb(1, 5'h08, 32'h8);
        wb(1, 5'h00, 32'h0);
        repeat (3 * WC) @(posedge clk_i);
        cmp("stall", 0, word_ready_flag_o);
        wb(0, 5'h04, 0);
        cmp("stalled", 1, rd[4]);
        wb(1, 5'h08, 32'h18);
        wait_ready();
        cmp("armed", 1, word_ready_flag_o);
        plot_en <= 1'b1;
        word(16'h0001);
        word(16'h0801);
        word(16'h7fe1);
        cmp("plot wait", 1, lat >= 58 && lat <= 70);
        plot_en <= 1'b0;
    endtask
    task automatic t_mark;
        wb(1, 5'h08, 32'h0000_0020);
        word(16'h0000);
        word(16'h0001);
        for (int i = 1; i <= 16; i++) begin
            word(16'h0801);
            word(16'h7fe1);
            cmp("marker", (i % 8) == 0, mk > 0);
        end
    endtask
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        #1_000_000;
        n_errors++;
        summarize();
    end
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_continuous_xy_type();
        t_point();
        t_bar();
        t_plot();
        t_mark();
        summarize();
    end
endmodule // xyds_word_sequencer_test
